// ### common/eew_pkg.sv
package eew_pkg;

  // Device type nibbles of the address byte.
  localparam logic [3:0] DEV_TYPE_MAIN  = 4'ha;
  localparam logic [3:0] DEV_TYPE_ID    = 4'hb;

  // Field positions inside the address byte.
  localparam int         TYPE_MSB       = 7;
  localparam int         TYPE_LSB       = 4;
  localparam int         STRAP_POS      = 3;
  localparam int         WA17_POS       = 2;
  localparam int         WA16_POS       = 1;
  localparam int         DIR_POS        = 0;

  // Word address layout and the identity page control bits.
  localparam int         ADDR_W         = 18;
  localparam int         LOCK_SEL_POS   = 10;
  localparam int         LOCK_DATA_POS  = 1;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  // Byte slots within one command.
  localparam logic [1:0] SLOT_DEV       = 2'h0;
  localparam logic [1:0] SLOT_ADDR_HI   = 2'h1;
  localparam logic [1:0] SLOT_ADDR_LO   = 2'h2;
  localparam logic [1:0] SLOT_DATA      = 2'h3;

  // Program time and the clock it is counted in.
  localparam int         PROG_TIME_NS   = 8000000;
  localparam int         CLK_PERIOD_NS  = 100;
  localparam int         PROG_CNT_W     = 20;

  // One received data byte on its way to the page latch.
  typedef struct packed {
    logic                 id_page;
    logic [ADDR_W-1:0]    addr;
    logic [7:0]           data;
  } eew_word_t;

  // Protocol states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RECV = 4'b0010,
    ST_ACK  = 4'b0100,
    ST_PROG = 4'b1000
  } eew_state_t;

endpackage : eew_pkg

// ### core/eew_write_path.sv
// Operation
// - Data changes only while clock low; changes with clock high are start or stop.
// - Falling data with clock high is a start; every command begins with one.
// - Rising data with clock high is a stop; it returns the device to standby.
// - Transfers are eight bits; device pulls data low on the ninth clock as acknowledge.
// - Standby after power-up and after a stop once internal work finishes.
// - Address byte: type 1010, strap bit, address bits 17 and 16, direction.
// - Strap bit must match the strap input; a floating strap reads as zero.
// - Lowest address-byte bit chooses read when one, write when zero.
// - Acknowledge a matching address; otherwise stay silent and go idle.
// - Two more address bytes, high then low, complete the 18-bit word address.
// - Write-protect high blocks all writes into the main array.
// - Byte write: acknowledge data, master stops, stop launches the program cycle.
// - During the program cycle, up to 8 ms, all inputs are ignored.
// - Page write: up to 256 data bytes, each acknowledged, ended by stop; the code does not acknowledge a byte that meets a full two-entry buffer.
// - Only the low eight address bits advance and wrap inside the page.
// - Identity page write uses type 1011, address bit 10 zero, low byte offset.
// - A locked identity page does not acknowledge identity page data bytes.
// - Lock command: type 1011, address bit 10 set, data bit 1 set.
// - Polling with the address byte gets acknowledge only after programming ends.
// - Sample on rising clock, change on falling clock, drive data only low.
module eew_write_path #(
  parameter int PROG_CYCLES = eew_pkg::PROG_TIME_NS / eew_pkg::CLK_PERIOD_NS
) (
  input  logic              MCLK,
  input  logic              SYS_RST,
  input  logic              SCL,
  input  logic              SDA_I,
  output logic              SDA_O,
  output logic              SDA_OE,
  input  logic              CHIP_SELECT_STRAP,
  input  logic              WP,
  output logic              WR_VALID,
  output eew_pkg::eew_word_t WR_WORD,
  input  logic              WR_READY,
  output logic              BUSY,
  output logic              STANDBY,
  output logic              ID_LOCKED
);
  import eew_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic [1:0] scl_sync_r, sda_sync_r, strap_sync_r, wp_sync_r;
  logic       scl_d_r, sda_d_r;
  // Two flops per pin; only the second stage and its delayed copy feed logic.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      scl_sync_r   <= 2'h3;
      sda_sync_r   <= 2'h3;
      strap_sync_r <= 2'h0;
      wp_sync_r    <= 2'h0;
      scl_d_r      <= 1'b1;
      sda_d_r      <= 1'b1;
    end
    else
    begin
      scl_sync_r   <= {scl_sync_r[0], SCL};
      sda_sync_r   <= {sda_sync_r[0], SDA_I};
      strap_sync_r <= {strap_sync_r[0], CHIP_SELECT_STRAP};
      wp_sync_r    <= {wp_sync_r[0], WP};
      scl_d_r      <= scl_sync_r[1];
      sda_d_r      <= sda_sync_r[1];
    end
  end
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  // Data edges while the clock stays high mark frame boundaries.
  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Byte decoding.
  eew_state_t        state_r;
  logic [3:0]        bitcnt_r;
  logic [1:0]        slot_r;
  logic [7:0]        shreg_r;
  logic [ADDR_W-1:0] addr_r;
  logic              sel_id_r, dir_rd_r, wrote_r, lock_pend_r, id_locked_r, sda_oe_r;
  logic              in_ready, push, byte_done, is_lock_cmd, data_ack;
  // True when a device address byte selects this part.
  function automatic logic dev_match(input logic [7:0] b, input logic strap);
    dev_match = (b[TYPE_MSB:TYPE_LSB] == DEV_TYPE_MAIN ||
                 b[TYPE_MSB:TYPE_LSB] == DEV_TYPE_ID) &&
                (b[STRAP_POS] == strap);
  endfunction : dev_match

  assign byte_done   = (state_r == ST_RECV) && scl_fall && (bitcnt_r == BITS_PER_BYTE);
  assign is_lock_cmd = sel_id_r & addr_r[LOCK_SEL_POS];
  // A data byte is refused when it cannot be kept; a protected main-array
  // byte is still acknowledged but dropped, so the master sees a normal write.
  always_comb
  begin
    data_ack = 1'b1;
    push     = 1'b0;
    if (byte_done && slot_r == SLOT_DATA && !dir_rd_r)
    begin
      if (is_lock_cmd)
        data_ack = 1'b1;
      else if (sel_id_r && id_locked_r)
        data_ack = 1'b0;
      else if (!sel_id_r && wp_sync_r[1])
        data_ack = 1'b1;
      else if (!in_ready)
        data_ack = 1'b0;
      else
        push = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state machine.
  logic [PROG_CNT_W-1:0] prog_cnt_r;
  logic                  prog_done;
  assign prog_done = (prog_cnt_r == PROG_CNT_W'(PROG_CYCLES - 1));
  // While programming nothing on the bus is seen, so a poll gets no ack.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      state_r <= ST_IDLE;
    else
      case (state_r)
        ST_PROG:
          if (prog_done)
            state_r <= ST_IDLE;
        ST_IDLE, ST_RECV, ST_ACK:
          if (stop_det && wrote_r)
            state_r <= ST_PROG;
          else if (stop_det)
            state_r <= ST_IDLE;
          else if (start_det)
            state_r <= ST_RECV;
          else if (byte_done)
          begin
            if (slot_r == SLOT_DEV && !dev_match(shreg_r, strap_sync_r[1]))
              state_r <= ST_IDLE;
            else if (slot_r == SLOT_DATA && !data_ack)
              state_r <= ST_IDLE;
            else
              state_r <= ST_ACK;
          end
          else if (state_r == ST_ACK && scl_fall)
            state_r <= dir_rd_r ? ST_IDLE : ST_RECV;
        default:
          state_r <= ST_IDLE;
      endcase
  end
  // Bits are taken on the rising clock edge, MSB first.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      shreg_r  <= 8'h00;
      bitcnt_r <= 4'h0;
    end
    else if (start_det || (state_r == ST_ACK && scl_fall))
      bitcnt_r <= 4'h0;
    else if (state_r == ST_RECV && scl_rise && bitcnt_r != BITS_PER_BYTE)
    begin
      shreg_r  <= {shreg_r[6:0], sda_s};
      bitcnt_r <= bitcnt_r + 4'h1;
    end
  end
  // Slot tracking and the word address.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      slot_r   <= SLOT_DEV;
      addr_r   <= '0;
      sel_id_r <= 1'b0;
      dir_rd_r <= 1'b0;
    end
    else if (state_r != ST_PROG && start_det)
      slot_r <= SLOT_DEV;
    else if (byte_done)
    begin
      case (slot_r)
        SLOT_DEV:
        begin
          sel_id_r   <= (shreg_r[TYPE_MSB:TYPE_LSB] == DEV_TYPE_ID);
          dir_rd_r   <= shreg_r[DIR_POS];
          addr_r[17] <= shreg_r[WA17_POS];
          addr_r[16] <= shreg_r[WA16_POS];
          slot_r     <= SLOT_ADDR_HI;
        end
        SLOT_ADDR_HI:
        begin
          addr_r[15:8] <= shreg_r;
          slot_r       <= SLOT_ADDR_LO;
        end
        SLOT_ADDR_LO:
        begin
          addr_r[7:0] <= shreg_r;
          slot_r      <= SLOT_DATA;
        end
        default:
          if (push)
            addr_r[7:0] <= addr_r[7:0] + 8'h01;
      endcase
    end
  end
  // Write bookkeeping; the lock becomes real only when its cycle completes.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      wrote_r     <= 1'b0;
      lock_pend_r <= 1'b0;
      id_locked_r <= 1'b0;
    end
    else if (state_r == ST_PROG)
    begin
      wrote_r <= 1'b0;
      if (prog_done && lock_pend_r)
      begin
        id_locked_r <= 1'b1;
        lock_pend_r <= 1'b0;
      end
    end
    else if (start_det)
    begin
      wrote_r     <= 1'b0;
      lock_pend_r <= 1'b0;
    end
    else if (byte_done && slot_r == SLOT_DATA && !dir_rd_r)
    begin
      if (is_lock_cmd && shreg_r[LOCK_DATA_POS] && !id_locked_r)
      begin
        lock_pend_r <= 1'b1;
        wrote_r     <= 1'b1;
      end
      else if (push)
        wrote_r <= 1'b1;
    end
  end
  // Program timer, counted only in the program state.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST || state_r != ST_PROG)
      prog_cnt_r <= '0;
    else if (!prog_done)
      prog_cnt_r <= prog_cnt_r + PROG_CNT_W'(1);
  end
  // Acknowledge drive: low from the falling edge that ends bit eight to the
  // falling edge that ends the ninth clock. The pin is never driven high.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      sda_oe_r <= 1'b0;
    else if (byte_done && state_r != ST_PROG)
      sda_oe_r <= (slot_r == SLOT_DEV) ? dev_match(shreg_r, strap_sync_r[1])
                                       : (slot_r != SLOT_DATA || data_ack);
    else if (scl_fall || start_det || stop_det)
      sda_oe_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer to the page latch; a full buffer refuses the byte.
  eew_word_t head_r, spare_r, in_word;
  logic      head_v_r, spare_v_r, pop;
  assign in_ready = ~spare_v_r;
  assign pop      = head_v_r & WR_READY;
  assign in_word  = '{id_page: sel_id_r,
                      addr:    sel_id_r ? {{(ADDR_W-8){1'b0}}, addr_r[7:0]} : addr_r,
                      data:    shreg_r};
  // The head is always the older word, so order is kept through a stall.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      head_v_r  <= 1'b0;
      spare_v_r <= 1'b0;
      head_r    <= '0;
      spare_r   <= '0;
    end
    else if (pop && spare_v_r)
    begin
      head_r    <= spare_r;
      spare_v_r <= 1'b0;
    end
    else if (pop)
    begin
      head_v_r <= push;
      head_r   <= in_word;
    end
    else if (push && !head_v_r)
    begin
      head_v_r <= 1'b1;
      head_r   <= in_word;
    end
    else if (push)
    begin
      spare_v_r <= 1'b1;
      spare_r   <= in_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  logic sda_o_r, busy_r, standby_r;
  // Status follows the state one cycle late, so no output is combinational.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      sda_o_r   <= 1'b0;
      busy_r    <= 1'b0;
      standby_r <= 1'b1;
    end
    else
    begin
      sda_o_r   <= 1'b0;
      busy_r    <= (state_r == ST_PROG);
      standby_r <= (state_r == ST_IDLE);
    end
  end
  // Every output is a flop or a plain copy of one.
  assign SDA_O     = sda_o_r;
  assign SDA_OE    = sda_oe_r;
  assign WR_VALID  = head_v_r;
  assign WR_WORD   = head_r;
  assign BUSY      = busy_r;
  assign STANDBY   = standby_r;
  assign ID_LOCKED = id_locked_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  sequence ack_seq;
    byte_done && sda_oe_r == 1'b0 ##1 sda_oe_r;
  endsequence
  sequence prog_enter_seq;
    stop_det && wrote_r && state_r != ST_PROG ##1 state_r == ST_PROG;
  endsequence
  ack_hold_a: assert property (ack_seq |-> state_r == ST_ACK)
    else $error("Acknowledge driven outside the ack phase.");
  start_recv_a: assert property (start_det && state_r != ST_PROG |=>
                                 state_r == ST_RECV && bitcnt_r == 4'h0)
    else $error("Start did not open a new byte.");
  stop_idle_a: assert property (stop_det && !wrote_r && state_r != ST_PROG |=>
                                state_r == ST_IDLE ##1 standby_r)
    else $error("Stop did not return to standby.");
  prog_quiet_a: assert property (state_r == ST_PROG |-> !sda_oe_r)
    else $error("Bus driven while programming.");
  no_match_a: assert property (byte_done && slot_r == SLOT_DEV &&
                               !dev_match(shreg_r, strap_sync_r[1]) |=>
                               state_r == ST_IDLE && !sda_oe_r)
    else $error("Mismatched address was acknowledged.");
  wp_block_a: assert property (push |-> sel_id_r || !wp_sync_r[1])
    else $error("Protected byte entered the buffer.");
  lock_block_a: assert property (push |-> !(sel_id_r && id_locked_r))
    else $error("Locked page byte entered the buffer.");
  page_wrap_a: assert property (push |=> addr_r[7:0] == $past(addr_r[7:0]) + 8'h01 &&
                                addr_r[17:8] == $past(addr_r[17:8]))
    else $error("Page address did not wrap correctly.");
  prog_busy_a: assert property (prog_enter_seq |-> prog_cnt_r == '0 ##1 busy_r)
    else $error("Program cycle did not start cleanly.");
endmodule : eew_write_path

// ### dv/eew_bus_master.sv
// Two-wire bus master stand-in; it drives the clock and pulls data only low.
module eew_bus_master (
  input  wire logic mclk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;

  // Both lines idle released, and the clock stands still between frames.
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Lines move only a fixed skew after an MCLK edge, so sampling never races.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  ////////////////////////////////////////////////////////////////////////////
  // Start or repeated start: data falls while the clock is high.
  task automatic start_c();
    sda_pull = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask : start_c

  // Data is set up in the low half, so it never moves under a high clock.
  task automatic send_bit(input logic b);
    sda_pull = ~b;
    tick(2);
    scl = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask : send_bit

  // MSB first; the ninth clock reads the answer with data released.
  // The low time after it is longer so the device lets go of data first.
  task automatic send_byte(input logic [7:0] b, output logic acked);
    for (int i = 7; i >= 0; i--)
      send_bit(b[i]);
    sda_pull = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(2);
    acked = (sda_in === 1'b0);
    tick(2);
    scl = 1'b0;
    tick(4);
  endtask : send_byte

  // Stop: data rises while the clock is high; it closes every write.
  task automatic stop_c();
    sda_pull = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask : stop_c

  // Recovery: up to nine clocks until data reads high, then a fresh start.
  task automatic recover();
    sda_pull = 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      tick(2);
      scl = 1'b1;
      tick(2);
      if (sda_in === 1'b1)
        break;
      tick(2);
      scl = 1'b0;
    end
    start_c();
  endtask : recover
endmodule : eew_bus_master

// ### dv/tb.sv
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("MISMATCH at %0t: got %h, expected %h", $time, (got), (exp)); \
    end \
  end

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import eew_pkg::*;

  localparam int PROG = 200;
  logic      mclk, sys_rst, strap, wp, latch_hold, sda_o, sda_oe;
  logic      wr_valid, busy, standby, id_locked, scl, sda_pull, ack;
  eew_word_t wr_word, w;
  eew_word_t got_q[$];
  int        n_errors, samples_checked;
  wire       sda;
  wire       wr_ready;

  // Open-drain wire with a pull-up: low while anyone pulls it.
  assign sda = ~(sda_pull | (sda_oe & ~sda_o));
  // The page latch stand-in refuses words while it is held.
  assign wr_ready = ~latch_hold;

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  eew_write_path #(.PROG_CYCLES(PROG)) dut_u (
    .MCLK(mclk), .SYS_RST(sys_rst), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .CHIP_SELECT_STRAP(strap), .WP(wp), .WR_VALID(wr_valid),
    .WR_WORD(wr_word), .WR_READY(wr_ready), .BUSY(busy), .STANDBY(standby),
    .ID_LOCKED(id_locked)
  );

  eew_bus_master bm_u (.mclk(mclk), .sda_in(sda), .scl(scl), .sda_pull(sda_pull));

  // The page latch stand-in takes a word on each edge where both sides agree.
  always @(posedge mclk)
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      got_q.push_back(wr_word);

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic xfer(input logic [7:0] b, input logic exp);
    bm_u.send_byte(b, ack);
    `CHK(ack, exp);
  endtask : xfer

  task automatic hdr(input logic [7:0] dev, input logic [7:0] hi, input logic [7:0] lo);
    bm_u.start_c();
    xfer(dev, 1'b1);
    xfer(hi, 1'b1);
    xfer(lo, 1'b1);
  endtask : hdr

  // Looks at the state once the stop has had time to land.
  task automatic after_stop(input logic prog);
    bm_u.stop_c();
    bm_u.tick(2);
    `CHK(busy, prog);
    `CHK(standby, ~prog);
  endtask : after_stop

  // Bounded wait for standby; a program cycle that never ends stops the run.
  task automatic wait_idle();
    int i;
    for (i = 0; i < 2 * PROG; i++)
    begin
      if (busy === 1'b0 && standby === 1'b1)
        break;
      bm_u.tick(1);
    end
    if (i == 2 * PROG)
    begin
      n_errors++;
      report_and_stop();
    end
  endtask : wait_idle

  task automatic chk_word(input eew_word_t exp);
    for (int i = 0; i < 50 && got_q.size() == 0; i++)
      bm_u.tick(1);
    if (got_q.size() == 0)
    begin
      n_errors++;
      report_and_stop();
    end
    w = got_q.pop_front();
    `CHK(w, exp);
  endtask : chk_word

  task automatic end_test(input string name);
    $display("Test %s done, mismatches so far %0d", name, n_errors);
  endtask : end_test

  ////////////////////////////////////////////////////////////////////////////
  // Guards the whole run against a hang anywhere.
  initial
  begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end

  // Main sequence: each block covers one or more write flavours, refusals or a read.
  initial
  begin
    sys_rst  = 1'b1;
    strap    = 1'b0;
    wp       = 1'b0;
    latch_hold = 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    `CHK({standby, busy, id_locked, wr_valid, sda_oe}, 5'h10);
    bm_u.tick(6);
    hdr(8'ha4, 8'h34, 8'hff);
    xfer(8'h5a, 1'b1);
    after_stop(1'b1);
    chk_word({1'b0, 18'h234ff, 8'h5a});
    bm_u.start_c();
    xfer(8'ha4, 1'b0);
    bm_u.stop_c();
    wait_idle();
    bm_u.start_c();
    xfer(8'ha4, 1'b1);
    after_stop(1'b0);
    end_test("byte write and polling");
    hdr(8'ha2, 8'h01, 8'hfe);
    for (int i = 0; i < 3; i++)
      xfer(8'(8'h10 + i), 1'b1);
    after_stop(1'b1);
    for (int i = 0; i < 3; i++)
      chk_word({1'b0, 2'b01, 8'h01, 8'(8'hfe + i), 8'(8'h10 + i)});
    wait_idle();
    end_test("page wrap");
    bm_u.start_c();
    bm_u.send_bit(1'b1);
    bm_u.send_bit(1'b0);
    bm_u.recover();
    xfer(8'hac, 1'b0);
    bm_u.start_c();
    xfer(8'h94, 1'b0);
    after_stop(1'b0);
    end_test("address refusals");
    wp    = 1'b1;
    strap = 1'b1;
    hdr(8'hac, 8'h00, 8'h10);
    xfer(8'h77, 1'b1);
    after_stop(1'b0);
    `CHK(got_q.size(), 0);
    wp    = 1'b0;
    strap = 1'b0;
    bm_u.start_c();
    xfer(8'ha5, 1'b1);
    after_stop(1'b0);
    end_test("protect and read");
    latch_hold = 1'b1;
    hdr(8'ha0, 8'h00, 8'h00);
    xfer(8'h21, 1'b1);
    xfer(8'h22, 1'b1);
    xfer(8'h23, 1'b0);
    `CHK({wr_valid, wr_word}, {1'b1, 1'b0, 18'h0, 8'h21});
    latch_hold = 1'b0;
    after_stop(1'b1);
    chk_word({1'b0, 18'h0, 8'h21});
    chk_word({1'b0, 18'h1, 8'h22});
    wait_idle();
    end_test("buffer stall");
    hdr(8'hb0, 8'hfb, 8'h07);
    xfer(8'h11, 1'b1);
    after_stop(1'b1);
    chk_word({1'b1, 18'h00007, 8'h11});
    wait_idle();
    hdr(8'hb0, 8'h04, 8'h00);
    xfer(8'h02, 1'b1);
    after_stop(1'b1);
    wait_idle();
    `CHK(id_locked, 1'b1);
    hdr(8'hb0, 8'h04, 8'h00);
    xfer(8'h02, 1'b1);
    after_stop(1'b0);
    hdr(8'hb0, 8'h00, 8'h00);
    xfer(8'h33, 1'b0);
    after_stop(1'b0);
    end_test("identity page");
    report_and_stop();
  end
endmodule : tb
